// ---- rtl/fan_cfg_pkg.sv ----
// Package of offsets, field positions, reset values and timing counts
// for the fan channel rate, slope and over-temperature configuration.
// Assumes a 50 MHz aclk and 32-bit AXI4-Lite register access.
package fan_cfg_pkg;
	localparam int NUM_CH = 3;
	localparam logic [7:0] OFS_CH0 = 8'h00;
	localparam logic [7:0] OFS_LOCK = 8'h0C;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	localparam logic [7:0] OFS_PINSTAT = 8'h18;
	localparam logic [7:0] OFS_DIV0 = 8'h20;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 3;
	localparam int DRIVE_BIT = 3;
	localparam int SLOPE_LSB = 4;
	localparam int SLOPE_W = 4;
	localparam logic [7:0] CH_RESET = 8'hC4;
	localparam int CLK_HZ = 50_000_000;
	localparam int RATE0_MHZ = 11_000;
	localparam int PWM_STEPS = 256;
	localparam int DIV0_CYCLES = CLK_HZ / (RATE0_MHZ * PWM_STEPS / 1000);
	localparam logic [23:0] DIV_RESET = 24'(DIV0_CYCLES);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [8:0] HYST_QUARTER = 9'h001;
endpackage : fan_cfg_pkg

// ---- rtl/fan_pwm_rate_overtemp_cfg.sv ----
// Per-channel slope, PWM rate and over-temperature pin configuration.
// Assumes temperatures arrive in quarter degrees, synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_rate_overtemp_cfg #(
	parameter int N = fan_cfg_pkg::NUM_CH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic monitor_cycle_done,
	input wire logic [N*9-1:0] temp_quarter,
	input wire logic [N*9-1:0] limit_quarter,
	input wire logic overtemp_signal_pin_i,
	output logic overtemp_signal_pin_o,
	output logic overtemp_signal_pin_oe,
	output logic [N-1:0] pwm_tick,
	output logic [N*4-1:0] duty_temperature_slope,
	output logic irq
);
	import fan_cfg_pkg::*;

	logic [7:0] ch_q [N];
	logic lock_q;
	logic [1:0] istat_q;
	logic [1:0] imask_q;
	logic [7:0] aw_q;
	logic aw_have_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic w_have_q;
	logic [N-1:0] hot_q;
	logic [N-1:0] held_q;
	logic pin_m_q;
	logic pin_s_q;
	logic pin_s_d_q;
	logic [23:0] cnt_q [N];
	logic [1:0] sel_q;
	logic [23:0] div_rd;
	logic [23:0] div_cur_q [N];

	wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	wire [5:0] wr_idx = aw_q[7:2];
	wire wr_div = do_write && aw_q[7:5] == OFS_DIV0[7:5];
	wire wr_lock = do_write && aw_q == OFS_LOCK;
	wire wr_istat = do_write && aw_q == OFS_ISTAT;
	wire wr_imask = do_write && aw_q == OFS_IMASK;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	logic [N-1:0] drive_en;
	wire any_drive = |(hot_q & drive_en);
	wire pin_fall = pin_s_d_q && !pin_s_q;
	wire [1:0] ev = {pin_fall, any_drive && !overtemp_signal_pin_oe};
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_val;

	always_comb begin
		wr_hit = wr_div || wr_lock || wr_istat || wr_imask;
		rd_hit = s_axi_araddr == OFS_LOCK || s_axi_araddr == OFS_ISTAT
			|| s_axi_araddr == OFS_IMASK || s_axi_araddr == OFS_PINSTAT;
		rd_val = 32'h00000000;
		for (int c = 0; c < N; c++) begin
			if (do_write && wr_idx == 6'(c)) begin
				wr_hit = 1'b1;
			end
			if (s_axi_araddr == OFS_CH0 + 8'(4 * c)) begin
				rd_hit = 1'b1;
				rd_val = {24'h000000, ch_q[c]};
			end
		end
		if (s_axi_araddr == OFS_LOCK) begin
			rd_val = {31'h00000000, lock_q};
		end
		if (s_axi_araddr == OFS_ISTAT) begin
			rd_val = {30'h00000000, istat_q};
		end
		if (s_axi_araddr == OFS_IMASK) begin
			rd_val = {30'h00000000, imask_q};
		end
		if (s_axi_araddr == OFS_PINSTAT) begin
			rd_val = {29'h00000000, overtemp_signal_pin_oe, pin_s_q, lock_q};
		end
	end

	// Write address and data are latched separately so either may lead.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h00000000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid
				&& s_axi_arvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// The lock is one-way; only a reset can open it again.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_q <= 1'b0;
			imask_q <= 2'h0;
		end else begin
			if (wr_lock && ws_q[0] && w_q[0]) begin
				lock_q <= 1'b1;
			end
			if (wr_imask && ws_q[0]) begin
				imask_q <= w_q[1:0];
			end
		end
	end

	// New events win over a write-one clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			istat_q <= 2'h0;
			irq <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~((wr_istat && ws_q[0]) ? w_q[1:0] : 2'h0))
				| ev;
			irq <= |(istat_q & imask_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_q <= 1'b1;
			pin_s_q <= 1'b1;
			pin_s_d_q <= 1'b1;
			overtemp_signal_pin_o <= 1'b0;
			overtemp_signal_pin_oe <= 1'b0;
			sel_q <= 2'h0;
		end else begin
			pin_m_q <= overtemp_signal_pin_i;
			pin_s_q <= pin_m_q;
			pin_s_d_q <= pin_s_q;
			overtemp_signal_pin_o <= 1'b0;
			overtemp_signal_pin_oe <= any_drive;
			sel_q <= (sel_q == 2'(N - 1)) ? 2'h0 : sel_q + 2'h1;
		end
	end

	rate_div_table #(
		.DEPTH(8),
		.WIDTH(24),
		.INIT(DIV_RESET)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.we(wr_div && !lock_q),
		.waddr(aw_q[4:2]),
		.wdata(w_q[23:0]),
		.raddr(ch_q[sel_q][RATE_LSB +: RATE_W]),
		.rdata(div_rd)
	);

	logic [1:0] sel_d_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_d_q <= 2'h0;
		end else begin
			sel_d_q <= sel_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			wire [8:0] t = temp_quarter[g*9 +: 9];
			wire [8:0] l = limit_quarter[g*9 +: 9];
			// One extra bit keeps a limit near full scale from wrapping.
			wire over = {1'b0, t} > {1'b0, l} + 10'(HYST_QUARTER);
			wire at_or_below = t <= l;
			assign drive_en[g] = ch_q[g][DRIVE_BIT];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ch_q[g] <= CH_RESET;
				end else if (do_write && wr_idx == 6'(g) && ws_q[0]
					&& !lock_q) begin
					ch_q[g] <= w_q[7:0];
				end
			end
			// Assertion holds until the next monitoring cycle end, then until the temperature is at or below the limit.
			always_ff @(posedge aclk) begin
				if (!aresetn || !drive_en[g]) begin
					hot_q[g] <= 1'b0;
					held_q[g] <= 1'b0;
				end else if (!hot_q[g]) begin
					hot_q[g] <= over;
					held_q[g] <= 1'b0;
				end else begin
					if (monitor_cycle_done) begin
						held_q[g] <= 1'b1;
					end
					if (held_q[g] && at_or_below) begin
						hot_q[g] <= 1'b0;
					end
				end
			end
			// Divider is reloaded from the table each time its slot comes.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					div_cur_q[g] <= DIV_RESET;
					cnt_q[g] <= 24'h000000;
					pwm_tick[g] <= 1'b0;
				end else begin
					if (sel_d_q == 2'(g)) begin
						div_cur_q[g] <= div_rd;
					end
					pwm_tick[g] <= cnt_q[g] == 24'h000000;
					cnt_q[g] <= (cnt_q[g] >= div_cur_q[g] - 24'h000001)
						? 24'h000000 : cnt_q[g] + 24'h000001;
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					duty_temperature_slope[g*4 +: 4] <= CH_RESET[7:4];
				end else begin
					duty_temperature_slope[g*4 +: 4] <=
						ch_q[g][SLOPE_LSB +: SLOPE_W];
				end
			end
		end
	endgenerate
endmodule : fan_pwm_rate_overtemp_cfg
`default_nettype wire

// ---- rtl/rate_div_table.sv ----
// Small memory holding the PWM clock divider for each rate code.
// Assumes one writer; read data leave through a register.
`timescale 1ns/1ps
`default_nettype none
module rate_div_table #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 24,
	parameter logic [23:0] INIT = 24'h000001
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [2:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	always_ff @(posedge aclk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (!aresetn) begin
				mem_q[i] <= WIDTH'(INIT) << i;
			end else if (we && waddr == 3'(i)) begin
				mem_q[i] <= wdata;
			end
		end
		rdata <= mem_q[raddr];
	end
endmodule : rate_div_table
`default_nettype wire

// ---- test/fan_cfg_chk.sv ----
// Port-level checker for the fan configuration block.
// Assumes one clock domain and the block's synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module fan_cfg_chk #(
	parameter int N = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic monitor_cycle_done,
	input wire logic [N*9-1:0] temp_quarter,
	input wire logic [N*9-1:0] limit_quarter,
	input wire logic overtemp_signal_pin_o,
	input wire logic overtemp_signal_pin_oe,
	input wire logic [N*4-1:0] duty_temperature_slope
);
	logic over;
	// Drive enables are not visible here, so any hot channel may be the cause.
	always_comb begin
		over = 1'b0;
		for (int c = 0; c < N; c++) begin
			over |= {1'b0, temp_quarter[c*9+:9]} >
				{1'b0, limit_quarter[c*9+:9]} + 10'h001;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
	sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
	property p_wr_resp; s_aw ##0 s_w |-> ##[1:2] s_axi_bvalid; endproperty
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_oe_cause; $rose(overtemp_signal_pin_oe) |-> $past(over, 2);
	endproperty
	property p_drive_low; overtemp_signal_pin_oe |-> !overtemp_signal_pin_o;
	endproperty
	property p_oe_min; $rose(overtemp_signal_pin_oe) && !monitor_cycle_done
		&& !s_axi_wvalid && !s_axi_bvalid |=> overtemp_signal_pin_oe;
	endproperty
	property p_slope_rst;
		$rose(aresetn) |-> ##1 duty_temperature_slope == {N{4'hC}};
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response missing");
	a_rd_resp: assert property (p_rd_resp)
		else $error("read data missing");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	a_oe_cause: assert property (p_oe_cause)
		else $error("pin driven without excess");
	a_drive_low: assert property (p_drive_low)
		else $error("pin driven high");
	a_oe_min: assert property (p_oe_min)
		else $error("pin released early");
	a_slope_rst: assert property (p_slope_rst)
		else $error("slope reset value wrong");
endmodule : fan_cfg_chk
bind fan_pwm_rate_overtemp_cfg fan_cfg_chk #(.N(N)) fan_cfg_chk_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.monitor_cycle_done(monitor_cycle_done), .temp_quarter(temp_quarter),
	.limit_quarter(limit_quarter),
	.overtemp_signal_pin_o(overtemp_signal_pin_o),
	.overtemp_signal_pin_oe(overtemp_signal_pin_oe),
	.duty_temperature_slope(duty_temperature_slope));
`default_nettype wire

// ---- test/hot_line_model.sv ----
// Far-side model of the over-temperature line: pull-up and processor.
// Assumes the device only ever pulls the line low, never high.
`timescale 1ns/1ps
`default_nettype none
module hot_line_model (
	input wire logic dev_oe,
	input wire logic dev_o,
	input wire logic hot_req,
	output logic line
);
	// A released line floats to the pull-up level, never the last value.
	assign line = ((dev_oe && !dev_o) || hot_req) ? 1'b0 : 1'b1;
endmodule : hot_line_model
`default_nettype wire

// ---- test/tb_fan_pwm_rate_overtemp_cfg.sv ----
// Self-checking bench for the fan configuration block.
// Assumes the hand-over register map and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_fan_pwm_rate_overtemp_cfg;
	import fan_cfg_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;
		logic [1:0] r;} row_s;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, done, pin, pin_o, pin_oe, irq, hot;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got_d, n;
	logic [1:0] bresp, rresp, got_r;
	logic [26:0] temp, limit;
	logic [2:0] tick;
	logic [11:0] slope;
	int failures, num_checks, cyc;
	// The divider table is write-only from the bus; its port feeds the rates.
	row_s rows [8] = '{'{1'b0, OFS_CH0, 0, 32'hC4, RESP_OKAY},
		'{1'b0, 8'h08, 0, 32'hC4, RESP_OKAY},
		'{1'b0, 8'h3C, 0, 0, RESP_SLVERR},
		'{1'b1, OFS_DIV0 + 8'h04, 32'h22, 0, RESP_OKAY},
		'{1'b1, 8'h04, 32'hA5, 0, RESP_OKAY},
		'{1'b0, 8'h04, 0, 32'hA5, RESP_OKAY},
		'{1'b0, 8'h1C, 0, 0, RESP_SLVERR},
		'{1'b1, 8'h40, 32'h1, 0, RESP_SLVERR}};
	fan_pwm_rate_overtemp_cfg fan_pwm_rate_overtemp_cfg_inst (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.monitor_cycle_done(done), .temp_quarter(temp), .limit_quarter(limit),
		.overtemp_signal_pin_i(pin), .overtemp_signal_pin_o(pin_o),
		.overtemp_signal_pin_oe(pin_oe), .pwm_tick(tick),
		.duty_temperature_slope(slope), .irq(irq));
	hot_line_model hot_line_model_inst (.dev_oe(pin_oe), .dev_o(pin_o),
		.hot_req(hot), .line(pin));
	always #10 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	// Each channel waits for its own ready; the response ends the transfer.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
		end while (!(w ? bvalid : rvalid));
		got_r = w ? bresp : rresp;
		got_d = rdata;
		bready <= 1'b0;
		rready <= 1'b0;
	endtask : xfer
	task automatic temp0(input logic [8:0] t);
		temp[8:0] <= t;
		repeat (4) @(posedge aclk);
	endtask : temp0
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{done, hot, awaddr, araddr, wdata} = '0;
		temp = {3{9'h032}};
		limit = {3{9'h064}};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			xfer(rows[i].w, rows[i].a, rows[i].d);
			chk(32'(got_r), 32'(rows[i].r));
			if (!rows[i].w) chk(got_d, rows[i].e);
		end
		chk(32'(slope[7:4]), 32'hA);
		xfer(1'b1, OFS_CH0, 32'hC0);
		do @(posedge aclk); while (!tick[0]);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!tick[0]);
		chk(n, 32'(DIV_RESET));
		xfer(1'b1, OFS_CH0, 32'hC1);
		do @(posedge aclk); while (!tick[0]);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!tick[0]);
		chk(n, 32'h22);
		xfer(1'b1, OFS_IMASK, 32'h3);
		xfer(1'b1, OFS_CH0, 32'hC8);
		temp0(9'h065);
		chk(32'(pin_oe), 32'h0);
		temp0(9'h066);
		chk(32'({pin_oe, pin, irq}), 32'h5);
		temp0(9'h064);
		chk(32'(pin_oe), 32'h1);
		done <= 1'b1;
		@(posedge aclk);
		done <= 1'b0;
		temp0(9'h064);
		chk(32'(pin_oe), 32'h0);
		xfer(1'b1, OFS_ISTAT, 32'h3);
		xfer(1'b1, OFS_CH0, 32'hC0);
		chk(32'(irq), 32'h0);
		hot <= 1'b1;
		temp0(9'h066);
		xfer(1'b0, OFS_PINSTAT, 0);
		chk(got_d, 32'h0);
		chk(32'(irq), 32'h1);
		xfer(1'b1, OFS_LOCK, 32'h1);
		xfer(1'b1, OFS_CH0, 32'h11);
		xfer(1'b0, OFS_CH0, 0);
		chk(got_d, 32'hC0);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		xfer(1'b0, OFS_CH0, 0);
		chk(got_d, 32'hC4);
		end_sim();
	end
endmodule : tb_fan_pwm_rate_overtemp_cfg
`default_nettype wire
